// [hdl/mcp_pkg.sv]
// constants and types for the mode-control serial port
package mcp_pkg;

  // four-wire command word
  localparam int         SPI_WORD_BITS   = 16;
  localparam logic [4:0] SPI_CNT_IDX_LAST = 5'h07;  // rise count before the 8th rise
  localparam logic [4:0] SPI_CNT_IDX_DONE = 5'h08;  // 8 bits taken: read data follows
  localparam logic [4:0] SPI_CNT_WORD     = 5'h10;  // 16 bits taken: write may commit

  // two-wire slave
  localparam logic [4:0] I2C_ADDR_PREFIX = 5'h13;   // fixed upper five address bits
  localparam logic [3:0] I2C_BIT_LAST    = 4'h7;
  localparam logic [3:0] I2C_BYTE_BITS   = 4'h8;

  // pins as seen after the synchroniser
  typedef struct packed {
    logic sel;     // front end select
    logic ms_n;    // port select, or lower strap
    logic mute;    // upper strap
    logic mc;      // bit clock, or scl
    logic control_serial_in;     // serial in, or sda
  } mcp_pins_t;

  typedef enum logic [2:0] {
    I2C_IDLE     = 3'h0,
    I2C_ADDR     = 3'h1,
    I2C_ADDR_ACK = 3'h3,
    I2C_RX       = 3'h2,
    I2C_RX_ACK   = 3'h6,
    I2C_TX       = 3'h7,
    I2C_TX_ACK   = 3'h5,
    I2C_WAIT     = 3'h4
  } mcp_i2c_state_t;

endpackage : mcp_pkg

// [hdl/mcp_control_port.sv]
// mode-control port: four-wire serial slave and two-wire slave front ends
//
// Summary of operation
// - select low: four-wire; select high: two-wire
// - four-wire port sampled on the system clock, bit clock synchronised
// - one 16-bit word per transaction, MSB first
// - next seven bits select the register
// - low byte: write value or read slots
// - read data shifts out after eighth clock
// - write commits after sixteenth clock completes
// - two-wire mode is slave only, both speeds
// - two-wire mode reuses pins as straps, scl, sda
// - address is prefix then upper, lower strap
// - answer only own address
// - index advances between data bytes, not after the last one
// - index wraps from top to zero
// - data byte written to undefined index gets no acknowledge
// - first read after write keeps index
`timescale 1ns/100ps
module mcp_control_port
  import mcp_pkg::*;
#(
  parameter int INDEX_W = 7,
  parameter int DATA_W  = 8
) (
  // clock and reset
  input  wire logic               I_CLK_SYS,
  input  wire logic               I_RSTN,
  // control pins
  input  wire logic               I_CONTROL_IFACE_SELECT,
  input  wire logic               I_PORT_SELECT_N,
  input  wire logic               I_MUTE,
  input  wire logic               I_CONTROL_BIT_CLOCK,
  input  wire logic               I_CONTROL_SERIAL_IN,
  output logic                    O_CONTROL_SERIAL_IN_OUT,
  output logic                    O_CONTROL_SERIAL_IN_OE_N,
  output logic                    O_CONTROL_SERIAL_OUT,
  output logic                    O_CONTROL_SERIAL_OUT_OE_N,
  // mode register access
  output logic                    O_REG_WR,
  output logic [INDEX_W-1:0]      O_REG_INDEX,
  output logic [DATA_W-1:0]       O_REG_WDATA,
  input  wire logic [DATA_W-1:0]  I_REG_RDATA,
  input  wire logic               I_REG_DEFINED
);

  if (INDEX_W != 7 || DATA_W != 8) begin : g_check
    $error("mcp_control_port serves a 7-bit index and 8-bit data only");
  end

  mcp_pins_t pin_meta_reg;
  mcp_pins_t pin_sync_reg;
  mcp_pins_t pin_prev_reg;

  // two flops per pin, third stage for edge finding and for qualifying port select
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pin_meta_reg <= '{sel: 1'b0, ms_n: 1'b1, mute: 1'b0, mc: 1'b0, control_serial_in: 1'b1};
      pin_sync_reg <= '{sel: 1'b0, ms_n: 1'b1, mute: 1'b0, mc: 1'b0, control_serial_in: 1'b1};
      pin_prev_reg <= '{sel: 1'b0, ms_n: 1'b1, mute: 1'b0, mc: 1'b0, control_serial_in: 1'b1};
    end else begin
      pin_meta_reg <= '{sel: I_CONTROL_IFACE_SELECT, ms_n: I_PORT_SELECT_N, mute: I_MUTE,
                        mc: I_CONTROL_BIT_CLOCK, control_serial_in: I_CONTROL_SERIAL_IN};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic i2c_mode;
  logic mc_rise;
  logic mc_fall;
  logic start_det;
  logic stop_det;
  logic spi_active;
  logic [6:0] own_addr;

  assign i2c_mode   = pin_sync_reg.sel;
  assign spi_active = !i2c_mode && !pin_sync_reg.ms_n && !pin_prev_reg.ms_n;
  assign mc_rise    = pin_sync_reg.mc && !pin_prev_reg.mc;
  assign mc_fall    = !pin_sync_reg.mc && pin_prev_reg.mc;
  assign start_det  = i2c_mode && pin_sync_reg.mc && pin_prev_reg.mc
                      && !pin_sync_reg.control_serial_in && pin_prev_reg.control_serial_in;
  assign stop_det   = i2c_mode && pin_sync_reg.mc && pin_prev_reg.mc
                      && pin_sync_reg.control_serial_in && !pin_prev_reg.control_serial_in;
  assign own_addr   = {I2C_ADDR_PREFIX, pin_sync_reg.mute, pin_sync_reg.ms_n};

  // ---------------- four-wire front end ----------------
  logic [4:0] spi_cnt_reg;
  logic [7:0] spi_sh_reg;
  logic [7:0] spi_out_sh_reg;
  logic       spi_rw_reg;
  logic       spi_idx_load;
  logic       spi_wr;

  assign spi_idx_load = spi_active && mc_rise && (spi_cnt_reg == SPI_CNT_IDX_LAST);
  // commit on the fall that completes the 16th clock
  assign spi_wr = spi_active && mc_fall && (spi_cnt_reg == SPI_CNT_WORD) && !spi_rw_reg;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      spi_cnt_reg <= 5'h00;
      spi_sh_reg  <= 8'h00;
      spi_rw_reg  <= 1'b0;
    end else if (!spi_active) begin
      spi_cnt_reg <= 5'h00;
    end else if (mc_rise && spi_cnt_reg < SPI_CNT_WORD) begin
      // clocks past the 16th are ignored
      spi_sh_reg  <= {spi_sh_reg[6:0], pin_sync_reg.control_serial_in};
      spi_cnt_reg <= spi_cnt_reg + 5'h01;
      if (spi_cnt_reg == 5'h00) begin
        spi_rw_reg <= pin_sync_reg.control_serial_in;
      end
    end else if (mc_wr_done(spi_wr)) begin
      spi_cnt_reg <= spi_cnt_reg + 5'h01;  // one commit per word
    end
  end

  function automatic logic mc_wr_done(input logic wr);
    return wr;
  endfunction : mc_wr_done

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_CONTROL_SERIAL_OUT      <= 1'b0;
      O_CONTROL_SERIAL_OUT_OE_N <= 1'b1;
      spi_out_sh_reg            <= 8'h00;
    end else if (!spi_active) begin
      O_CONTROL_SERIAL_OUT      <= 1'b0;
      O_CONTROL_SERIAL_OUT_OE_N <= 1'b1;
    end else begin
      O_CONTROL_SERIAL_OUT_OE_N <= 1'b0;
      if (mc_fall && spi_rw_reg) begin
        if (spi_cnt_reg == SPI_CNT_IDX_DONE) begin
          O_CONTROL_SERIAL_OUT <= I_REG_RDATA[7];
          spi_out_sh_reg       <= {I_REG_RDATA[6:0], 1'b0};
        end else if (spi_cnt_reg > SPI_CNT_IDX_DONE && spi_cnt_reg < SPI_CNT_WORD) begin
          O_CONTROL_SERIAL_OUT <= spi_out_sh_reg[7];
          spi_out_sh_reg       <= {spi_out_sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  // ---------------- two-wire front end ----------------
  mcp_i2c_state_t state_reg;
  logic [3:0]     bit_cnt_reg;
  logic [7:0]     i2c_sh_reg;
  logic [7:0]     tx_sh_reg;
  logic           i2c_rw_reg;
  logic           first_byte_reg;
  logic           inc_pending_reg;
  logic           i2c_edge_ok;
  logic           i2c_idx_load;
  logic           i2c_idx_inc;
  logic           i2c_wr;
  logic [7:0]     rx_byte;

  assign i2c_edge_ok  = i2c_mode && !start_det && !stop_det;
  assign rx_byte      = {i2c_sh_reg[6:0], pin_sync_reg.control_serial_in};
  assign i2c_idx_load = i2c_edge_ok && state_reg == I2C_RX && mc_rise
                        && bit_cnt_reg == I2C_BIT_LAST && first_byte_reg;
  // deferred step keeps a following read on the written register
  assign i2c_idx_inc  = i2c_edge_ok && mc_rise
                        && ((state_reg == I2C_RX && bit_cnt_reg == I2C_BIT_LAST
                             && !first_byte_reg && inc_pending_reg)
                            || (state_reg == I2C_TX_ACK && !pin_sync_reg.control_serial_in));
  assign i2c_wr       = i2c_edge_ok && state_reg == I2C_RX && mc_fall
                        && bit_cnt_reg == I2C_BYTE_BITS && !first_byte_reg && I_REG_DEFINED;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_reg                <= I2C_IDLE;
      bit_cnt_reg              <= 4'h0;
      i2c_sh_reg               <= 8'h00;
      tx_sh_reg                <= 8'h00;
      i2c_rw_reg               <= 1'b0;
      first_byte_reg           <= 1'b1;
      inc_pending_reg          <= 1'b0;
      O_CONTROL_SERIAL_IN_OE_N <= 1'b1;
    end else if (!i2c_mode) begin
      state_reg                <= I2C_IDLE;
      O_CONTROL_SERIAL_IN_OE_N <= 1'b1;
    end else if (start_det) begin
      state_reg                <= I2C_ADDR;  // repeated start too
      bit_cnt_reg              <= 4'h0;
      first_byte_reg           <= 1'b1;
      O_CONTROL_SERIAL_IN_OE_N <= 1'b1;
    end else if (stop_det) begin
      state_reg                <= I2C_IDLE;
      O_CONTROL_SERIAL_IN_OE_N <= 1'b1;
    end else begin
      case (state_reg)
        I2C_ADDR, I2C_RX: begin
          if (mc_rise) begin
            i2c_sh_reg  <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (mc_fall && bit_cnt_reg == I2C_BYTE_BITS) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == I2C_ADDR) begin
              if (i2c_sh_reg[7:1] == own_addr) begin
                i2c_rw_reg               <= i2c_sh_reg[0];
                O_CONTROL_SERIAL_IN_OE_N <= 1'b0;
                state_reg                <= I2C_ADDR_ACK;
              end else begin
                state_reg <= I2C_WAIT;
              end
            end else if (first_byte_reg || I_REG_DEFINED) begin
              O_CONTROL_SERIAL_IN_OE_N <= 1'b0;
              inc_pending_reg          <= !first_byte_reg;
              state_reg                <= I2C_RX_ACK;
            end else begin
              state_reg <= I2C_WAIT;
            end
          end
        end
        I2C_ADDR_ACK: begin
          if (mc_fall) begin
            if (i2c_rw_reg) begin
              O_CONTROL_SERIAL_IN_OE_N <= I_REG_RDATA[7];
              tx_sh_reg                <= {I_REG_RDATA[6:0], 1'b1};
              inc_pending_reg          <= 1'b0;
              state_reg                <= I2C_TX;
            end else begin
              O_CONTROL_SERIAL_IN_OE_N <= 1'b1;
              state_reg                <= I2C_RX;
            end
          end
        end
        I2C_RX_ACK: begin
          if (mc_fall) begin
            O_CONTROL_SERIAL_IN_OE_N <= 1'b1;
            first_byte_reg           <= 1'b0;
            state_reg                <= I2C_RX;
          end
        end
        I2C_TX: begin
          if (mc_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (mc_fall) begin
            if (bit_cnt_reg == I2C_BYTE_BITS) begin
              bit_cnt_reg              <= 4'h0;
              O_CONTROL_SERIAL_IN_OE_N <= 1'b1;  // hand sda to master for ack
              state_reg                <= I2C_TX_ACK;
            end else begin
              O_CONTROL_SERIAL_IN_OE_N <= tx_sh_reg[7];
              tx_sh_reg                <= {tx_sh_reg[6:0], 1'b1};
            end
          end
        end
        I2C_TX_ACK: begin
          if (mc_rise && pin_sync_reg.control_serial_in) begin
            state_reg <= I2C_WAIT;  // master nack ends the read
          end else if (mc_fall) begin
            O_CONTROL_SERIAL_IN_OE_N <= I_REG_RDATA[7];
            tx_sh_reg                <= {I_REG_RDATA[6:0], 1'b1};
            state_reg                <= I2C_TX;
          end
        end
        default: begin
          O_CONTROL_SERIAL_IN_OE_N <= 1'b1;  // idle or wait for start/stop
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_CONTROL_SERIAL_IN_OUT <= 1'b0;
    end else begin
      O_CONTROL_SERIAL_IN_OUT <= 1'b0;
    end
  end

  // ---------------- shared register access ----------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_REG_INDEX <= 7'h00;
    end else if (spi_idx_load) begin
      O_REG_INDEX <= {spi_sh_reg[5:0], pin_sync_reg.control_serial_in};
    end else if (i2c_idx_load) begin
      O_REG_INDEX <= rx_byte[6:0];
    end else if (i2c_idx_inc) begin
      O_REG_INDEX <= O_REG_INDEX + 7'h01;  // natural wrap 7f to 0
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_REG_WR    <= 1'b0;
      O_REG_WDATA <= 8'h00;
    end else begin
      O_REG_WR <= spi_wr || i2c_wr;
      if (spi_wr) begin
        O_REG_WDATA <= spi_sh_reg;
      end else if (i2c_wr) begin
        O_REG_WDATA <= i2c_sh_reg;
      end
    end
  end

endmodule : mcp_control_port

// [verification/mcp_sva.sv]
// concurrent checks on the mode-control port
`timescale 1ns/100ps
module mcp_sva
  import mcp_pkg::*;
#(
  parameter int INDEX_W = 7,
  parameter int DATA_W  = 8
) (
  // clock and reset
  input wire logic               I_CLK_SYS,
  input wire logic               I_RSTN,
  // pins
  input wire logic               I_CONTROL_IFACE_SELECT,
  input wire logic               I_PORT_SELECT_N,
  input wire logic               I_MUTE,
  input wire logic               I_CONTROL_BIT_CLOCK,
  input wire logic               I_CONTROL_SERIAL_IN,
  input wire logic               O_CONTROL_SERIAL_IN_OUT,
  input wire logic               O_CONTROL_SERIAL_IN_OE_N,
  input wire logic               O_CONTROL_SERIAL_OUT,
  input wire logic               O_CONTROL_SERIAL_OUT_OE_N,
  // register access
  input wire logic               O_REG_WR,
  input wire logic [INDEX_W-1:0] O_REG_INDEX,
  input wire logic [DATA_W-1:0]  O_REG_WDATA,
  input wire logic [DATA_W-1:0]  I_REG_RDATA,
  input wire logic               I_REG_DEFINED
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  sequence s_spi_idle;
    !I_CONTROL_IFACE_SELECT && I_PORT_SELECT_N;
  endsequence
  sequence s_spi_commit;
    O_REG_WR && !I_CONTROL_IFACE_SELECT;
  endsequence
  property p_wr_pulse; O_REG_WR |=> !O_REG_WR; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_float; s_spi_idle [*6] |-> O_CONTROL_SERIAL_OUT_OE_N; endproperty
  a_float: assert property (p_float) else $error("readback driven while idle");
  property p_i2c_quiet; I_CONTROL_IFACE_SELECT [*6] |-> O_CONTROL_SERIAL_OUT_OE_N; endproperty
  a_i2c_quiet: assert property (p_i2c_quiet) else $error("readback driven in two-wire");
  property p_spi_no_sda; !I_CONTROL_IFACE_SELECT [*6] |-> O_CONTROL_SERIAL_IN_OE_N; endproperty
  a_spi_no_sda: assert property (p_spi_no_sda) else $error("data pin pulled in four-wire");
  property p_od; !O_CONTROL_SERIAL_IN_OE_N |-> !O_CONTROL_SERIAL_IN_OUT; endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  property p_wr_idx; O_REG_WR |-> $stable(O_REG_INDEX); endproperty
  a_wr_idx: assert property (p_wr_idx) else $error("index moved on write");
  property p_wr_def; O_REG_WR && I_CONTROL_IFACE_SELECT |-> I_REG_DEFINED; endproperty
  a_wr_def: assert property (p_wr_def) else $error("write to undefined index");
  property p_spi_commit; s_spi_commit |-> !I_CONTROL_BIT_CLOCK && !I_PORT_SELECT_N; endproperty
  a_spi_commit: assert property (p_spi_commit) else $error("commit out of place");
  property p_out_hold; I_CONTROL_BIT_CLOCK [*8] |=> $stable(O_CONTROL_SERIAL_OUT); endproperty
  a_out_hold: assert property (p_out_hold) else $error("readback moved with clock high");
endmodule : mcp_sva

bind mcp_control_port mcp_sva #(.INDEX_W(INDEX_W), .DATA_W(DATA_W)) u_sva (.*);

// [verification/mcp_host.sv]
// host model: master on the four-wire and the two-wire control links
`timescale 1ns/100ps
module mcp_host (
  // clock and sensed pins
  input  wire logic i_clk,
  input  wire logic i_line,
  input  wire logic i_rdback,
  // driven pins
  output logic      o_mc,
  output logic      o_ms_n,
  output logic      o_dout
);
  initial begin
    o_mc = 1'b0;
    o_ms_n = 1'b1;
    o_dout = 1'b1;
  end
  // half of a 160 ns link clock
  task automatic q();
    repeat (20) @(negedge i_clk);
  endtask : q
  task automatic spi(input logic [15:0] w, input int n, output logic [7:0] rd);
    o_ms_n = 1'b0; // select per word
    for (int i = 15; i > 15 - n; i--) begin // msb first
      o_dout = w[i];
      q();
      o_mc = 1'b1;
      if (i < 8) rd[i] = i_rdback; // sampled on rise
      q();
      o_mc = 1'b0;
    end
    q();
    o_ms_n = 1'b1; // deselect between words
    o_dout = ~o_dout;
    q();
  endtask : spi
  task automatic start(); // master owns framing
    o_dout = 1'b1;
    q();
    o_mc = 1'b1;
    q();
    o_dout = 1'b0;
    q();
    o_mc = 1'b0;
    q();
  endtask : start
  task automatic stop();
    o_dout = 1'b0;
    q();
    o_mc = 1'b1;
    q();
    o_dout = 1'b1;
    q();
  endtask : stop
  // eight bits plus acknowledge slot; 1 releases the line
  task automatic byte9(input logic [8:0] t, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      o_dout = t[i];
      q();
      o_mc = 1'b1;
      q();
      r[i] = i_line;
      o_mc = 1'b0;
    end
  endtask : byte9
endmodule : mcp_host

// [verification/tb.sv]
// testbench: host model drives the port, bench checks strobes and readback
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import mcp_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sel = 1'b0;
  logic        mute = 1'b0;
  logic        mc, ms_n, dout, line, rdback, def;
  logic        wr, sda_oe_n, sda_o, control_serial_out, mdo_oe_n;
  logic [6:0]  idx;
  logic [7:0]  wdata, rd, v, w2;
  logic [8:0]  r9;
  logic [14:0] e;
  logic [7:0]  regs [128] = '{default: 8'h00};
  logic [14:0] expq [$];
  int          n_fail = 0;
  int          num_checks = 0;
  int          seed = 14943;
  int          cyc = 0;
  always #2 clk = ~clk;
  // open-drain line with pull-up; released readback shows inverted level
  assign line = dout & (sda_oe_n | sda_o);
  assign rdback = mdo_oe_n ? ~control_serial_out : control_serial_out;
  assign def = (idx < 7'h18) || (idx == 7'h7f); // arbitrary defined map
  mcp_host u_host (.i_clk(clk), .i_line(line), .i_rdback(rdback), .o_mc(mc),
    .o_ms_n(ms_n), .o_dout(dout));
  mcp_control_port u_dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_CONTROL_IFACE_SELECT(sel),
    .I_PORT_SELECT_N(ms_n), .I_MUTE(mute), .I_CONTROL_BIT_CLOCK(mc),
    .I_CONTROL_SERIAL_IN(line), .O_CONTROL_SERIAL_IN_OUT(sda_o),
    .O_CONTROL_SERIAL_IN_OE_N(sda_oe_n), .O_CONTROL_SERIAL_OUT(control_serial_out),
    .O_CONTROL_SERIAL_OUT_OE_N(mdo_oe_n), .O_REG_WR(wr), .O_REG_INDEX(idx),
    .O_REG_WDATA(wdata), .I_REG_RDATA(regs[idx]), .I_REG_DEFINED(def));
  task automatic results();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      n_fail++;
      results();
    end
    if (wr === 1'b1) begin
      e = expq.size() ? expq.pop_front() : 'x;
      `CHK({idx, wdata}, e) // index and value of a commit
      regs[idx] <= wdata;
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    v = $random(seed);
    expq.push_back({7'h05, v});
    u_host.spi({1'b0, 7'h05, v}, 16, rd); // write word
    u_host.spi({1'b1, 7'h05, 8'h00}, 16, rd);
    `CHK(rd, v) // readback of a written value
    u_host.spi({1'b0, 7'h06, v}, 12, rd); // cut short, no commit
    fork
      u_host.spi({1'b0, 7'h07, v}, 16, rd);
      begin
        repeat (300) @(negedge clk);
        rstn = 1'b0; // reset in mid-word
        repeat (2) @(negedge clk);
        rstn = 1'b1;
      end
    join
    for (int i = 6; i < 8; i++) begin
      u_host.spi({1'b1, i[6:0], 8'h00}, 16, rd);
      `CHK(rd, 8'h00) // dropped words left registers alone
    end
    sel = 1'b1; // two-wire with straps 0,1
    u_host.stop();
    for (int a = 0; a < 4; a++) begin
      u_host.start();
      u_host.byte9({I2C_ADDR_PREFIX, a[1:0], 1'b0, 1'b1}, r9);
      `CHK(r9[0], a != 1) // only own address acked
      u_host.stop();
    end
    v = $random(seed);
    w2 = $random(seed);
    expq.push_back({7'h7f, v});
    expq.push_back({7'h00, w2});
    u_host.start();
    u_host.byte9({7'h4d, 1'b0, 1'b1}, r9);
    u_host.byte9({8'h7f, 1'b1}, r9);
    u_host.byte9({v, 1'b1}, r9);
    `CHK(r9[0], 1'b0) // data byte acked
    u_host.byte9({w2, 1'b1}, r9);
    `CHK(r9[0], 1'b0) // index wrapped to zero
    u_host.start();
    u_host.byte9({7'h4d, 1'b1, 1'b1}, r9);
    u_host.byte9({8'hff, 1'b0}, r9);
    `CHK(r9[8:1], w2) // first read keeps index
    u_host.byte9({8'hff, 1'b1}, r9);
    `CHK(r9[8:1], regs[1]) // read advances index
    u_host.stop();
    u_host.start();
    u_host.byte9({7'h4d, 1'b0, 1'b1}, r9);
    u_host.byte9({8'h20, 1'b1}, r9);
    u_host.byte9({v, 1'b1}, r9);
    `CHK(r9[0], 1'b1) // undefined index refused
    u_host.stop();
    repeat (50) @(negedge clk);
    `CHK(expq.size(), 0) // every expected commit seen
    results();
  end
endmodule : tb
